/* rtl/dbr_pkg.sv */
// Package with the register map, field layout, reset values and states of the bus release sequencer.
package dbr_pkg;

	// Sequencer states, Gray coded along request, acknowledge, read, write and pause.
	typedef enum logic [2:0] {
		DBR_IDLE    = 3'h0,
		DBR_REQ     = 3'h1,
		DBR_ACKED   = 3'h3,
		DBR_READ    = 3'h2,
		DBR_WRITE   = 3'h6,
		DBR_PAUSE   = 3'h7,
		DBR_RELEASE = 3'h5
	} dbr_state_e;

	// Register byte addresses on the Wishbone slave.
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_TIMING = 8'h04;
	localparam logic [7:0] ADDR_LENGTH = 8'h08;
	localparam logic [7:0] ADDR_SRC    = 8'h0C;
	localparam logic [7:0] ADDR_DST    = 8'h10;
	localparam logic [7:0] ADDR_MATCH  = 8'h14;
	localparam logic [7:0] ADDR_VECTOR = 8'h18;
	localparam logic [7:0] ADDR_CMD    = 8'h1C;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	localparam logic [7:0] ADDR_COUNT  = 8'h24;

	// Control register bit positions.
	localparam int CTRL_ENABLE     = 0;
	localparam int CTRL_MODE_LO    = 1;
	localparam int CTRL_SEQ        = 3;
	localparam int CTRL_STOP_EOB   = 4;
	localparam int CTRL_STOP_MATCH = 5;
	localparam int CTRL_RDY_HIGH   = 6;
	localparam int CTRL_WAIT_EN    = 7;
	localparam int CTRL_VARIABLE   = 8;
	localparam int CTRL_PULSE_EN   = 9;
	localparam int CTRL_SRC_IO     = 10;
	localparam int CTRL_DST_IO     = 11;
	localparam int CTRL_INT_EOB    = 12;
	localparam int CTRL_INT_MATCH  = 13;
	localparam int CTRL_W          = 14;

	// Transfer mode codes in the control mode field.
	localparam logic [1:0] MODE_BYTE  = 2'h0;
	localparam logic [1:0] MODE_BURST = 2'h1;
	localparam logic [1:0] MODE_CONT  = 2'h2;

	// Timing register fields: cycle length codes, early end bits, pulse byte.
	localparam int TIM_RD_LEN   = 0;
	localparam int TIM_WR_LEN   = 2;
	localparam int TIM_EARLY_IO = 4;
	localparam int TIM_EARLY_MR = 5;
	localparam int TIM_EARLY_RD = 6;
	localparam int TIM_EARLY_WR = 7;
	localparam int TIM_PULSE    = 8;

	// Reset values.
	localparam logic [CTRL_W-1:0] CTRL_RESET = 14'h0040;
	localparam logic [15:0] TIMING_RESET     = 16'h0000;
	localparam logic [15:0] LENGTH_RESET     = 16'h0001;

	// Standard cycle lengths in bus clocks.
	localparam logic [2:0] STD_MEM_LEN = 3'h3;
	localparam logic [2:0] STD_IO_LEN  = 3'h4;

	// Command and instruction bytes seen on the data bus.
	localparam logic [7:0] CMD_ENABLE_AFTER_RETURN_FROM_IRQ = 8'hB7;
	localparam logic [7:0] RETURN_FROM_IRQ_FIRST            = 8'hED;
	localparam logic [7:0] RETURN_FROM_IRQ_SECOND           = 8'h4D;

endpackage : dbr_pkg

/* rtl/dbr_cycle_gen.sv */
// Half-clock resolved read or write cycle generator with strobes, wait sampling and ready sample.
`timescale 1ns/100ps
module dbr_cycle_gen
	import dbr_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       start_i,
	input  wire logic [2:0] len_i,
	input  wire logic       is_io_i,
	input  wire logic       is_write_i,
	input  wire logic       variable_i,
	input  wire logic [3:0] early_i,
	input  wire logic       wait_en_i,
	input  wire logic       wait_n_i,
	output logic            busy_o,
	output logic            sample_rdy_o,
	output logic            done_o,
	output logic            io_n_o,
	output logic            mem_n_o,
	output logic            rd_n_o,
	output logic            wr_n_o
);

	typedef struct packed {
		logic       busy;
		logic [3:0] h;
	} dbr_cg_s;

	dbr_cg_s    s;
	dbr_cg_s    next_s;
	logic [3:0] last;
	logic [3:0] wait_pt;
	logic       wait_ok;

	// Each clk_i cycle is one half of a bus clock; even halves begin at a bus rising edge.
	always_comb begin
		next_s  = s;
		last    = {len_i, 1'b0} - 4'h1;
		wait_pt = is_io_i ? 4'h5 : 4'h3;
		wait_ok = wait_en_i & (is_io_i ? (len_i == 3'h4) : (len_i >= 3'h3));
		if (s.busy) begin
			if (s.h == last) begin
				next_s.busy = start_i; // A start on the final half chains the next cycle.
				next_s.h    = 4'h0;
			end else if (wait_ok && s.h == wait_pt && !wait_n_i) begin
				next_s.h = wait_pt - 4'h1; // One extra bus clock, then sample again.
			end else begin
				next_s.h = s.h + 4'h1;
			end
		end else if (start_i) begin
			next_s.busy = 1'b1;
			next_s.h    = 4'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// Strobes start at T1 falling, IO at T1 rising in variable mode, and may end half early.
	assign io_n_o  = ~(s.busy & is_io_i & (s.h >= {3'h0, ~variable_i})
		& ((s.h != last) | ~early_i[0]));
	assign mem_n_o = ~(s.busy & ~is_io_i & (s.h >= 4'h1) & ((s.h != last) | ~early_i[1]));
	assign rd_n_o  = ~(s.busy & ~is_write_i & (s.h >= 4'h1) & ((s.h != last) | ~early_i[2]));
	assign wr_n_o  = ~(s.busy & is_write_i & (s.h >= 4'h1) & ((s.h != last) | ~early_i[3]));
	assign busy_o       = s.busy;
	assign done_o       = s.busy & (s.h == last);
	assign sample_rdy_o = s.busy & (s.h == last - 4'h1); // Rising edge of the last clock.

endmodule : dbr_cycle_gen

/* rtl/dbr_bus_release.sv */
// Bus master sequencer of a byte-wide DMA engine with Wishbone register access.
//
// Notes on behaviour
// - Stop on end of block releases the request on the edge finishing the last transfer.
// - The last byte of a block completes even if ready drops during it.
// - Stop on match releases at end of the next read, or the following write.
// - Byte comparison runs one cycle behind the read, overlapping the next cycle.
// - Ready dropping after a matching operation does not move the match release.
// - Burst mode with ready inactive finishes the byte, then releases next rising edge.
// - Continuous mode with ready inactive finishes the byte, keeps the bus, idles.
// - Ready is sampled as a level at the last clock of every cycle.
// - Byte and burst with ready inactive keep strobes high and drivers off.
// - Continuous pause keeps the incremented next address driven.
// - Read and write cycle lengths set separately to two, three or four clocks.
// - Each strobe's trailing edge can separately end half a clock early.
// - Variable timing asserts the IO request half a clock before other strobes.
// - Wait input sampled only in long memory or four clock IO cycles.
// - Read data is latched as read ends and held through the write.
// - Variable continuous mode holds the IO request during pause until stopping.
// - During interrupt acknowledge the interrupting device drives its vector.
// - The two-byte return instruction on the data bus clears the in-service latch.
// - Pulse generation pulls interrupt low when pulse byte equals count low byte.
// - Each pulse lasts one whole transfer cycle.
// - Transfer starts the rising edge after acknowledge is low on two edges.
// - Ready polarity is programmable high or low.
//
// The register offsets and the Wishbone register port are this design's own decisions.
`timescale 1ns/100ps
module dbr_bus_release
	import dbr_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             bus_request_n_o,
	input  wire logic        bus_ack_in_n_i,
	input  wire logic        ready_i,
	input  wire logic        chip_enable_wait_n_i,
	output logic      [15:0] addr_o,
	output logic             addr_oe_o,
	input  wire logic [7:0]  data_i,
	output logic      [7:0]  data_o,
	output logic             data_oe_o,
	output logic             control_oe_o,
	output logic             mem_request_n_o,
	input  wire logic        io_request_n_i,
	output logic             io_request_n_o,
	output logic             read_strobe_n_o,
	output logic             write_strobe_n_o,
	input  wire logic        opcode_fetch_n_i,
	output logic             interrupt_n_o,
	output logic             interrupt_oe_o
);

	typedef struct packed {
		dbr_state_e        st;
		logic              phase;
		logic [CTRL_W-1:0] ctrl;
		logic [15:0]       timing;
		logic [15:0]       length;
		logic [15:0]       src;
		logic [15:0]       dst;
		logic [15:0]       count;
		logic [15:0]       match;
		logic [7:0]        vector;
		logic              bus_req_n;
		logic              ack_seen;
		logic              rdy_ok;
		logic [7:0]        data;
		logic              cmp_pend;
		logic              match_hit;
		logic              eob;
		logic              pulse;
		logic              irq_pend;
		logic              in_service;
		logic              return_from_irq_arm;
		logic              prev_ed;
		logic              fetch_q;
		logic [7:0]        fetch_byte;
		logic              vec_drive;
		logic              wb_ack;
		logic [31:0]       wb_dat;
	} dbr_main_s;

	dbr_main_s  s;
	dbr_main_s  next_s;
	logic       start;
	logic       is_write;
	logic       is_io;
	logic [2:0] len;
	logic       rdy_act;
	logic       cont;
	logic       stop;
	logic       cg_busy;
	logic       cg_sample;
	logic       cg_done;
	logic       cg_io_n;
	logic       cg_mem_n;
	logic       cg_rd_n;
	logic       cg_wr_n;

	// Byte-lane merge for 16-bit registers written over the bus.
	function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] new_v,
			input logic [3:0] sel);
		merge16 = {sel[1] ? new_v[15:8] : old_v[15:8], sel[0] ? new_v[7:0] : old_v[7:0]};
	endfunction : merge16

	// Cycle length from a two-bit code: two, three or four clocks.
	function automatic logic [2:0] code_len(input logic [1:0] code);
		code_len = (code == 2'h3) ? 3'h4 : {1'b0, code} + 3'h2;
	endfunction : code_len

	// Cycle parameters follow the state; the cycle generator only reads them while busy.
	always_comb begin
		is_write = (s.st == DBR_WRITE);
		is_io    = is_write ? s.ctrl[CTRL_DST_IO] : s.ctrl[CTRL_SRC_IO];
		if (s.ctrl[CTRL_VARIABLE]) begin
			len = code_len(is_write ? s.timing[TIM_WR_LEN +: 2] : s.timing[TIM_RD_LEN +: 2]);
		end else begin
			len = is_io ? STD_IO_LEN : STD_MEM_LEN;
		end
		rdy_act = ready_i ~^ s.ctrl[CTRL_RDY_HIGH];
		cont    = (s.ctrl[CTRL_MODE_LO +: 2] == MODE_CONT);
	end

	// Sequencer, register file, match pipeline, interrupt and return decoding.
	always_comb begin
		next_s = s;
		start  = 1'b0;
		stop   = 1'b0;
		next_s.phase = ~s.phase;

		// Wishbone classic slave: one wait state, write lands on the acknowledged edge.
		next_s.wb_ack = wb_cyc_i & wb_stb_i & ~s.wb_ack;
		if (wb_cyc_i && wb_stb_i && !s.wb_ack) begin
			unique case (wb_adr_i)
				ADDR_CTRL:   next_s.wb_dat = {18'h0, s.ctrl};
				ADDR_TIMING: next_s.wb_dat = {16'h0, s.timing};
				ADDR_LENGTH: next_s.wb_dat = {16'h0, s.length};
				ADDR_SRC:    next_s.wb_dat = {16'h0, s.src};
				ADDR_DST:    next_s.wb_dat = {16'h0, s.dst};
				ADDR_MATCH:  next_s.wb_dat = {16'h0, s.match};
				ADDR_VECTOR: next_s.wb_dat = {24'h0, s.vector};
				ADDR_STATUS: next_s.wb_dat = {21'h0, rdy_act, s.return_from_irq_arm, s.pulse, s.irq_pend,
					s.in_service, s.match_hit, s.eob, s.bus_req_n, s.st};
				ADDR_COUNT:  next_s.wb_dat = {16'h0, s.count};
				default:     next_s.wb_dat = 32'h0;
			endcase
		end
		if (wb_cyc_i && wb_stb_i && s.wb_ack && wb_we_i) begin
			unique case (wb_adr_i)
				ADDR_CTRL: begin
					next_s.ctrl = CTRL_W'(merge16({2'h0, s.ctrl}, wb_dat_i, wb_sel_i));
					if (wb_sel_i[0] && wb_dat_i[CTRL_ENABLE] && !s.ctrl[CTRL_ENABLE]) begin
						next_s.count     = 16'h0;
						next_s.eob       = 1'b0;
						next_s.match_hit = 1'b0;
					end
				end
				ADDR_TIMING: next_s.timing = merge16(s.timing, wb_dat_i, wb_sel_i);
				ADDR_LENGTH: next_s.length = merge16(s.length, wb_dat_i, wb_sel_i);
				ADDR_SRC:    next_s.src    = merge16(s.src, wb_dat_i, wb_sel_i);
				ADDR_DST:    next_s.dst    = merge16(s.dst, wb_dat_i, wb_sel_i);
				ADDR_MATCH:  next_s.match  = merge16(s.match, wb_dat_i, wb_sel_i);
				ADDR_VECTOR: if (wb_sel_i[0]) next_s.vector = wb_dat_i[7:0];
				ADDR_CMD: begin
					if (wb_sel_i[0] && wb_dat_i[7:0] == CMD_ENABLE_AFTER_RETURN_FROM_IRQ) begin
						next_s.return_from_irq_arm = 1'b1;
					end
				end
				default: ;
			endcase
		end

		// Ready level is captured at the last clock of each cycle.
		if (cg_sample) begin
			next_s.rdy_ok = rdy_act;
		end

		// The compare runs the cycle after the read latch, while the next cycle proceeds.
		if (s.cmp_pend) begin
			next_s.cmp_pend  = 1'b0;
			next_s.match_hit = ((s.data ^ s.match[7:0]) & ~s.match[15:8]) == 8'h0;
		end

		unique case (s.st)
			DBR_IDLE: begin
				if (s.ctrl[CTRL_ENABLE] && rdy_act && bus_ack_in_n_i && s.phase) begin
					next_s.bus_req_n = 1'b0;
					next_s.ack_seen  = 1'b0;
					next_s.st        = DBR_REQ;
				end
			end
			DBR_REQ: begin
				if (s.phase) begin
					next_s.ack_seen = ~bus_ack_in_n_i;
					if (!bus_ack_in_n_i && s.ack_seen) begin
						next_s.st = DBR_ACKED; // Second consecutive low edge.
					end
				end
			end
			DBR_ACKED: begin
				if (s.phase) begin
					if (rdy_act) begin
						start     = 1'b1; // First cycle begins on the next rising edge.
						next_s.st = DBR_READ;
					end else if (cont) begin
						next_s.st = DBR_PAUSE;
					end else begin
						next_s.st = DBR_RELEASE;
					end
				end
			end
			DBR_READ, DBR_WRITE: begin
				if (cg_done && s.st == DBR_READ) begin
					next_s.data     = data_i; // Latched as the read strobe rises.
					next_s.cmp_pend = 1'b1;
					next_s.src      = s.src + 16'h1;
				end
				if (cg_done && s.st == DBR_WRITE) begin
					next_s.dst = s.dst + 16'h1;
				end
				if (cg_done && s.st == DBR_READ && s.ctrl[CTRL_SEQ]) begin
					start     = 1'b1;
					next_s.st = DBR_WRITE;
				end else if (cg_done) begin
					// End of one byte operation; ready is not looked at for the stop.
					next_s.count = s.count + 16'h1;
					next_s.pulse = 1'b0;
					next_s.eob   = (s.count + 16'h1) == s.length;
					stop = (next_s.eob & s.ctrl[CTRL_STOP_EOB])
						| (s.match_hit & s.ctrl[CTRL_STOP_MATCH]);
					if (stop) begin
						next_s.bus_req_n          = 1'b1; // Same edge as the last transfer.
						next_s.ctrl[CTRL_ENABLE]  = 1'b0;
						next_s.irq_pend = s.irq_pend | (next_s.eob & s.ctrl[CTRL_INT_EOB])
							| (s.match_hit & s.ctrl[CTRL_INT_MATCH]);
						next_s.st = DBR_IDLE;
					end else if (s.ctrl[CTRL_MODE_LO +: 2] == MODE_BYTE) begin
						next_s.bus_req_n = 1'b1;
						next_s.st        = DBR_IDLE;
					end else if (!s.rdy_ok && !cont) begin
						next_s.st = DBR_RELEASE;
					end else if (!s.rdy_ok) begin
						next_s.st = DBR_PAUSE;
					end else begin
						start     = 1'b1;
						next_s.st = DBR_READ;
					end
				end
			end
			DBR_PAUSE: begin
				if (s.phase && s.match_hit && s.ctrl[CTRL_STOP_MATCH]) begin
					next_s.bus_req_n         = 1'b1;
					next_s.ctrl[CTRL_ENABLE] = 1'b0;
					next_s.st                = DBR_IDLE;
				end else if (s.phase && rdy_act) begin
					start     = 1'b1;
					next_s.st = DBR_READ;
				end
			end
			DBR_RELEASE: begin
				if (s.phase) begin
					next_s.bus_req_n = 1'b1; // Next rising edge after the byte.
					next_s.st        = DBR_IDLE;
				end
			end
			default: begin
				next_s.bus_req_n = 1'b1;
				next_s.st        = DBR_IDLE;
			end
		endcase

		// Pulse output starts with the read of the matching byte count.
		if (start && next_s.st == DBR_READ && s.ctrl[CTRL_PULSE_EN]
				&& s.timing[TIM_PULSE +: 8] == next_s.count[7:0]) begin
			next_s.pulse = 1'b1;
		end

		// Interrupt acknowledge: fetch and IO request low together.
		if (!opcode_fetch_n_i && !io_request_n_i && s.bus_req_n) begin
			if (s.irq_pend && !s.in_service) begin
				next_s.vec_drive  = 1'b1;
				next_s.in_service = 1'b1;
				next_s.irq_pend   = 1'b0;
			end
		end else begin
			next_s.vec_drive = 1'b0;
		end

		// Return instruction decode from the opcode bytes of consecutive fetches.
		next_s.fetch_q = opcode_fetch_n_i;
		if (!opcode_fetch_n_i) begin
			next_s.fetch_byte = data_i;
		end
		if (opcode_fetch_n_i && !s.fetch_q) begin
			next_s.prev_ed = (s.fetch_byte == RETURN_FROM_IRQ_FIRST);
			if (s.prev_ed && s.fetch_byte == RETURN_FROM_IRQ_SECOND) begin
				next_s.in_service = 1'b0;
				if (s.return_from_irq_arm) begin
					next_s.return_from_irq_arm          = 1'b0;
					next_s.ctrl[CTRL_ENABLE] = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s           <= '0;
			s.st        <= DBR_IDLE;
			s.ctrl      <= CTRL_RESET;
			s.timing    <= TIMING_RESET;
			s.length    <= LENGTH_RESET;
			s.bus_req_n <= 1'b1;
			s.fetch_q   <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	dbr_cycle_gen u_cycle (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.start_i      (start),
		.len_i        (len),
		.is_io_i      (is_io),
		.is_write_i   (is_write),
		.variable_i   (s.ctrl[CTRL_VARIABLE]),
		.early_i      (s.timing[TIM_EARLY_WR:TIM_EARLY_IO]),
		.wait_en_i    (s.ctrl[CTRL_WAIT_EN]),
		.wait_n_i     (chip_enable_wait_n_i),
		.busy_o       (cg_busy),
		.sample_rdy_o (cg_sample),
		.done_o       (cg_done),
		.io_n_o       (cg_io_n),
		.mem_n_o      (cg_mem_n),
		.rd_n_o       (cg_rd_n),
		.wr_n_o       (cg_wr_n)
	);

	// Address and control drive only while owning the bus, data also for the vector; pause keeps the next address up.
	assign control_oe_o     = (s.st == DBR_ACKED) | (s.st == DBR_READ) | (s.st == DBR_WRITE)
		| (s.st == DBR_PAUSE);
	assign addr_oe_o        = cg_busy | (s.st == DBR_PAUSE);
	assign addr_o           = (s.st == DBR_WRITE) ? s.dst : s.src;
	assign data_oe_o        = (s.st == DBR_WRITE) | s.vec_drive;
	assign data_o           = s.vec_drive ? s.vector : s.data;
	assign mem_request_n_o  = cg_mem_n;
	assign io_request_n_o   = cg_io_n & ~((s.st == DBR_PAUSE) & s.ctrl[CTRL_VARIABLE]
		& s.ctrl[CTRL_SRC_IO]);
	assign read_strobe_n_o  = cg_rd_n;
	assign write_strobe_n_o = cg_wr_n;
	assign bus_request_n_o  = s.bus_req_n;
	assign interrupt_oe_o   = s.pulse | (s.irq_pend & ~s.in_service);
	assign interrupt_n_o    = 1'b0;
	assign wb_ack_o         = s.wb_ack;
	assign wb_dat_o         = s.wb_dat;

endmodule : dbr_bus_release

/* verif/dbr_bus_release_asserts.sv */
// Concurrent checks on the ports of the bus release sequencer.
`timescale 1ns/100ps
module dbr_bus_release_chk (
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	input wire logic       bus_request_n_o,
	input wire logic       bus_ack_in_n_i,
	input wire logic       addr_oe_o,
	input wire logic [7:0] data_o,
	input wire logic       data_oe_o,
	input wire logic       control_oe_o,
	input wire logic       mem_request_n_o,
	input wire logic       read_strobe_n_o,
	input wire logic       write_strobe_n_o,
	input wire logic       opcode_fetch_n_i,
	input wire logic       io_request_n_i,
	input wire logic       interrupt_oe_o
);
	// Every check runs on the system clock and rests during reset.
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	property p_wb_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_wb_ack: assert property (p_wb_ack) else $error("ack not a one cycle answer");
	property p_grant;
		$rose(control_oe_o) |-> !$past(bus_ack_in_n_i) && !$past(bus_ack_in_n_i, 2);
	endproperty
	a_grant: assert property (p_grant) else $error("bus taken early");
	property p_idle;
		bus_request_n_o && $past(bus_request_n_o, 3) |-> !addr_oe_o && !control_oe_o;
	endproperty
	a_idle: assert property (p_idle) else $error("bus driven while idle");
	property p_strobe_own;
		!(mem_request_n_o && read_strobe_n_o && write_strobe_n_o) |-> control_oe_o;
	endproperty
	a_strobe_own: assert property (p_strobe_own) else $error("strobe off bus");
	property p_write_data;
		!write_strobe_n_o |-> data_oe_o && $stable(data_o);
	endproperty
	a_write_data: assert property (p_write_data) else $error("write data moved");
	property p_release;
		$rose(bus_request_n_o) |-> ##[0:2] !control_oe_o && !addr_oe_o;
	endproperty
	a_release: assert property (p_release) else $error("bus kept after release");
	property p_vector;
		data_oe_o && !control_oe_o |-> !$past(opcode_fetch_n_i) && !$past(io_request_n_i);
	endproperty
	a_vector: assert property (p_vector) else $error("data driven outside acknowledge");
	property p_pulse;
		$rose(interrupt_oe_o) && control_oe_o |-> interrupt_oe_o [*4];
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse too short");

	// Main scenarios reached.
	c_release: cover property ($rose(bus_request_n_o));
	c_write: cover property ($fell(write_strobe_n_o));
	c_pulse: cover property ($rose(interrupt_oe_o) && control_oe_o);
endmodule : dbr_bus_release_chk

bind dbr_bus_release dbr_bus_release_chk u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .bus_request_n_o(bus_request_n_o), .bus_ack_in_n_i(bus_ack_in_n_i),
	.addr_oe_o(addr_oe_o), .data_o(data_o), .data_oe_o(data_oe_o), .control_oe_o(control_oe_o),
	.mem_request_n_o(mem_request_n_o), .read_strobe_n_o(read_strobe_n_o),
	.write_strobe_n_o(write_strobe_n_o), .opcode_fetch_n_i(opcode_fetch_n_i),
	.io_request_n_i(io_request_n_i), .interrupt_oe_o(interrupt_oe_o));

/* verif/dbr_host_model.sv */
// Behavioural processor and memory standing on the far side of the sequencer.
`timescale 1ns/100ps
module dbr_host_model
	import dbr_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        slow_i,
	input  wire logic        bus_request_n_i,
	input  wire logic [15:0] addr_i,
	input  wire logic        read_strobe_n_i,
	input  wire logic        write_strobe_n_i,
	input  wire logic [7:0]  dma_data_i,
	input  wire logic        cpu_drive_i,
	input  wire logic [7:0]  cpu_data_i,
	output logic             bus_ack_in_n_o,
	output logic             wait_n_o,
	output logic      [7:0]  data_o,
	output logic      [15:0] wr_addr_o,
	output logic      [7:0]  wr_data_o
);
	logic [5:0] grant_dly;
	logic [7:0] last_data;

	// Grant follows the request after a short or long delay; writes are recorded.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			grant_dly <= 6'h3F;
			last_data <= 8'h00;
		end else begin
			grant_dly <= {grant_dly[4:0], bus_request_n_i};
			last_data <= data_o;
		end
		if (!write_strobe_n_i) begin
			wr_addr_o <= addr_i;
			wr_data_o <= dma_data_i;
		end
	end

	// Memory answers with the low address byte; an undriven bus keeps toggling.
	assign bus_ack_in_n_o = slow_i ? grant_dly[5] : grant_dly[1];
	assign wait_n_o       = 1'b1;
	assign data_o = cpu_drive_i ? cpu_data_i : (!read_strobe_n_i ? addr_i[7:0] : ~last_data);
endmodule : dbr_host_model

/* verif/test_dbr_bus_release.sv */
// Self-checking bench of the bus release sequencer with the host model.
`timescale 1ns/100ps
module test_dbr_bus_release;
	import dbr_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic        ack, req_n, ack_in_n, wait_n, addr_oe, data_oe, ctl_oe, rd_n, wr_n, int_oe;
	logic        rdy = 1'b1;
	logic        fetch_n = 1'b1;
	logic        cpu_io_n = 1'b1;
	logic        cpu_drv = 1'b0;
	logic        slow = 1'b0;
	logic        pulse_seen = 1'b0;
	logic [7:0]  din, dout, wr_data;
	logic [7:0]  cpu_d = 8'h00;
	logic [15:0] addr, wr_addr, v;
	logic [15:0] ct [3] = '{16'h0055, 16'h0053, 16'h0013};
	logic        lvl [3] = '{1'b0, 1'b0, 1'b1};
	logic [15:0] ex [3] = '{16'h0001, 16'h0002, 16'h0002};
	int          error_cnt = 0;
	int          n_tests = 0;

	dbr_bus_release dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.bus_request_n_o(req_n), .bus_ack_in_n_i(ack_in_n), .ready_i(rdy),
		.chip_enable_wait_n_i(wait_n), .addr_o(addr), .addr_oe_o(addr_oe), .data_i(din),
		.data_o(dout), .data_oe_o(data_oe), .control_oe_o(ctl_oe), .mem_request_n_o(),
		.io_request_n_i(cpu_io_n), .io_request_n_o(), .read_strobe_n_o(rd_n),
		.write_strobe_n_o(wr_n), .opcode_fetch_n_i(fetch_n), .interrupt_n_o(),
		.interrupt_oe_o(int_oe));
	dbr_host_model host (
		.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .bus_request_n_i(req_n), .addr_i(addr),
		.read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n), .dma_data_i(dout),
		.cpu_drive_i(cpu_drv), .cpu_data_i(cpu_d), .bus_ack_in_n_o(ack_in_n),
		.wait_n_o(wait_n), .data_o(din), .wr_addr_o(wr_addr), .wr_data_o(wr_data));

	// Clock at 100 MHz.
	always #5 clk_i = ~clk_i;

	// Remember a pulse seen on the interrupt line while the bus is owned.
	always @(posedge clk_i) begin
		if (int_oe === 1'b1 && ctl_oe === 1'b1) begin
			pulse_seen <= 1'b1;
		end
	end

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One classic Wishbone cycle; read data lands in v.
	task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {16'h0000, d};
		do @(posedge clk_i); while (ack !== 1'b1);
		v = rdat[15:0];
		cyc <= 1'b0;
		we <= 1'b0;
	endtask : wb

	task automatic run(input logic [15:0] src, input logic [15:0] len, input logic [15:0] ctl);
		wb(1'b1, ADDR_SRC, src);
		wb(1'b1, ADDR_LENGTH, len);
		wb(1'b1, ADDR_CTRL, ctl);
	endtask : run

	// Poll until the engine clears its enable after a stop.
	task automatic wait_idle;
		for (int i = 0; i < 400; i++) begin
			wb(1'b0, ADDR_CTRL, 16'h0000);
			if (v[0] === 1'b0) break;
		end
	endtask : wait_idle

	// One processor fetch or acknowledge cycle; v holds drive enable and data.
	task automatic cpu_cycle(input logic [7:0] b, input logic io);
		@(posedge clk_i);
		fetch_n <= 1'b0;
		cpu_io_n <= io;
		cpu_drv <= io;
		cpu_d <= b;
		repeat (3) @(posedge clk_i);
		v = {7'h00, data_oe, dout};
		fetch_n <= 1'b1;
		cpu_io_n <= 1'b1;
		cpu_drv <= 1'b0;
	endtask : cpu_cycle

	task automatic final_report;
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report

	// Watchdog for a hung run.
	initial begin
		#400000;
		error_cnt++;
		final_report();
	end

	// Main sequence.
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, ADDR_CTRL, 16'h0000);
		chk("ctrl reset", 16'h0040, v);
		wb(1'b0, ADDR_LENGTH, 16'h0000);
		chk("length reset", 16'h0001, v);
		wb(1'b0, 8'h30, 16'h0000);
		chk("unmapped", 16'h0000, v);
		wb(1'b1, ADDR_VECTOR, 16'h005A);
		wb(1'b1, ADDR_DST, 16'h2000);
		// Burst sequential block with stop and interrupt at its end.
		run(16'h1000, 16'h0003, 16'h105B);
		wait_idle();
		wb(1'b0, ADDR_COUNT, 16'h0000);
		chk("eob count", 16'h0003, v);
		wb(1'b0, ADDR_STATUS, 16'h0000);
		chk("eob status", 16'h0018, v & 16'h0018);
		chk("last write addr", 16'h2002, wr_addr);
		chk("last write data", 16'h0002, {8'h00, wr_data});
		// Acknowledge, then the two-byte return.
		cpu_cycle(8'h00, 1'b0);
		chk("vector", 16'h015A, v);
		wb(1'b0, ADDR_STATUS, 16'h0000);
		chk("in service", 16'h0040, v & 16'h0040);
		wb(1'b1, ADDR_LENGTH, 16'h0004);
		wb(1'b1, ADDR_CTRL, 16'h005A);
		wb(1'b1, ADDR_CMD, {8'h00, CMD_ENABLE_AFTER_RETURN_FROM_IRQ});
		cpu_cycle(RETURN_FROM_IRQ_FIRST, 1'b1);
		cpu_cycle(RETURN_FROM_IRQ_SECOND, 1'b1);
		wb(1'b0, ADDR_STATUS, 16'h0000);
		chk("service cleared", 16'h0000, v & 16'h0040);
		wait_idle();
		wb(1'b0, ADDR_COUNT, 16'h0000);
		chk("reenable count", 16'h0004, v);
		// Search with stop on match, slow grant.
		slow <= 1'b1;
		wb(1'b1, ADDR_MATCH, 16'h0002);
		run(16'h3000, 16'h000A, 16'h0063);
		wait_idle();
		wb(1'b0, ADDR_COUNT, 16'h0000);
		chk("match count", 16'h0004, v);
		slow <= 1'b0;
		// Ready dropped mid block: continuous, burst, burst with low-active ready.
		for (int k = 0; k < 3; k++) begin
			rdy <= ~lvl[k];
			run(16'h4000, 16'h0006, ct[k]);
			wait (ctl_oe === 1'b1);
			repeat (8) @(posedge clk_i);
			rdy <= lvl[k];
			repeat (40) @(posedge clk_i);
			chk("ready drop", ex[k], {14'h0, req_n, addr_oe});
			rdy <= ~lvl[k];
			wait_idle();
			wb(1'b0, ADDR_COUNT, 16'h0000);
			chk("ready count", 16'h0006, v);
		end
		// Variable two-clock IO reads with early IO end and pulse byte one.
		rdy <= 1'b1;
		pulse_seen <= 1'b0;
		wb(1'b1, ADDR_TIMING, 16'h0110);
		run(16'h6000, 16'h0004, 16'h0753);
		wait_idle();
		wb(1'b0, ADDR_COUNT, 16'h0000);
		chk("variable count", 16'h0004, v);
		chk("pulse", 16'h0001, {15'h0, pulse_seen});
		final_report();
	end
endmodule : test_dbr_bus_release
